/* File: core/ivs_defines.svh */
`ifndef IVS_DEFINES_SVH
`define IVS_DEFINES_SVH

`define IVS_CALL_OPCODE  8'hcd
`define IVS_SPUR_LEVEL   3'h7
`define IVS_SLAVE_ID_RST 3'h7
`define IVS_MASK_RST     8'h00
`define IVS_EDGE_REARM   8'hff
`define IVS_PIN_RST      21'h1e0000

`define IVS_W1_INIT      4
`define IVS_W1_ADDR_HI   7
`define IVS_W1_ADDR_LO   5
`define IVS_W1_LEVEL_TRIGGER_SEL      3
`define IVS_W1_ADI       2
`define IVS_W1_LONE_DEVICE_FLAG      1
`define IVS_W1_IC4       0
`define IVS_W4_AUTO_SERVICE_CLEAR      1
`define IVS_W4_PM        0

`define IVS_OW_THIRD     3
`define IVS_OW_ESMM      6
`define IVS_OW_SMM       5
`define IVS_OW_RR        1
`define IVS_OW_RIS       0
`define IVS_EOI_NSPEC    3'h1
`define IVS_EOI_SPEC     3'h3

`endif

/* File: core/ivs_pkg.sv */
package ivs_pkg;

	typedef enum logic [4:0] {
		INIT_WAIT   = 5'h01,
		INIT_BASE   = 5'h02,
		INIT_CASC   = 5'h04,
		INIT_FOURTH = 5'h08,
		INIT_READY  = 5'h10
	} ivs_init_t;

	typedef enum logic [5:0] {
		ACK_IDLE = 6'h01,
		ACK_P1   = 6'h02,
		ACK_G1   = 6'h04,
		ACK_P2   = 6'h08,
		ACK_G2   = 6'h10,
		ACK_P3   = 6'h20
	} ivs_ack_t;

	typedef logic [2:0] ivs_level_t;

endpackage : ivs_pkg

/* File: core/ivs_sync.sv */
`timescale 1ns/1ns
module ivs_sync #(
	parameter int               WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input  wire logic             clock_i,
	input  wire logic             reset_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			meta_q <= RESET_VAL;
			sync_q <= RESET_VAL;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule : ivs_sync

/* File: core/ivs_prio.sv */
`timescale 1ns/1ns
module ivs_prio (
	input  wire logic       [7:0] bits_i,
	output logic                  found_o,
	output ivs_pkg::ivs_level_t   level_o
);

	// Scanning down lets the lowest set index win, so input 0 ranks first.
	always_comb begin
		found_o = 1'b0;
		level_o = 3'h0;
		for (int i = 7; i >= 0; i--) begin
			if (bits_i[i]) begin
				found_o = 1'b1;
				level_o = 3'(i);
			end
		end
	end

endmodule : ivs_prio

/* File: core/ivs_top.sv */
`timescale 1ns/1ns
`include "ivs_defines.svh"
// Contract
// - Raise the interrupt output when an unmasked request outranks service.
// - Call mode first ack sets service bit, clears request, drives opcode.
// - Call mode drives address low byte on ack two, high on three.
// - Call mode auto clear drops service bit at third ack end.
// - Pointer mode first ack sets service, clears request, bus undriven.
// - Pointer mode drives one eight-bit vector on the second ack.
// - Pointer mode auto clear drops service bit at second ack end.
// - No request at first ack answers as level seven everywhere.
// - Interval four low byte: address 7..5, level, two zeros.
// - Interval eight low byte: address 7..6, level, three zeros.
// - Third call byte is the stored base word, address 15..8.
// - Pointer byte: five top base bits, then level; interval ignored.
// - Pointer first ack freezes the level; cascade code after it.
// - Write with address low and data bit four restarts setup.
// - Setup start rearms edges; each input needs a fresh rise.
// - Setup start clears mask, special mask, slave id seven, reads requests.
// - Without fourth word, auto clear and pointer mode are zeroed.
// - Level trigger select makes inputs level sensed, no edge logic.
// - Spacing select one gives interval four, zero interval eight.
// - Lone device skips cascade word; fourth flag expects fourth word.
// - Processor mode bit zero selects call, one selects pointer.
// - Non-specific end command clears lowest-numbered set service bit, skipping masked ones in special mask mode.
// - Auto clear is enabled by its bit in the fourth word.
module ivs_top (
	input  wire logic       clock_i,
	input  wire logic       reset_i,
	input  wire logic       cs_n_i,
	input  wire logic       wr_n_i,
	input  wire logic       rd_n_i,
	input  wire logic       a0_i,
	input  wire logic [7:0] data_i,
	input  wire logic       vector_ack_strobe_n_i,
	input  wire logic [7:0] request_i,
	output logic      [7:0] data_o,
	output logic            data_oe_n_o,
	output logic            int_o,
	output logic      [2:0] cas_o,
	output logic            cas_oe_n_o,
	output logic      [2:0] slave_id_o
);

	function automatic logic ivs_is_init(input logic a0, input logic [7:0] d);
		return !a0 && d[`IVS_W1_INIT];
	endfunction : ivs_is_init

	function automatic logic [7:0] ivs_onehot(input logic [2:0] l);
		return 8'h01 << l;
	endfunction : ivs_onehot

	logic [20:0] pins_s;
	logic        s_cs_n, s_wr_n, s_rd_n, s_ack_n, s_a0;
	logic [7:0]  s_data, s_req;

	// Every pin is asynchronous to clock_i, so all pass two flops.
	ivs_sync #(.WIDTH(21), .RESET_VAL(`IVS_PIN_RST)) u_sync (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.async_i ({cs_n_i, wr_n_i, rd_n_i, vector_ack_strobe_n_i, a0_i,
		           data_i, request_i}),
		.sync_o  (pins_s)
	);
	assign {s_cs_n, s_wr_n, s_rd_n, s_ack_n, s_a0, s_data, s_req} = pins_s;

	// Host strobe front end.
	logic       wr_act_q, wr_act_d, wr_a0_q, wr_a0_d, ack_low_q, ack_low_d;
	logic [7:0] wr_data_q, wr_data_d;
	logic       wr_act, wr_stb, wr_init, rd_act, ack_fall, ack_rise;

	assign wr_act   = !s_cs_n && !s_wr_n;
	assign rd_act   = !s_cs_n && !s_rd_n;
	assign wr_stb   = wr_act_q && !wr_act;
	assign wr_init  = wr_stb && ivs_is_init(wr_a0_q, wr_data_q);
	assign ack_fall = !s_ack_n && !ack_low_q;
	assign ack_rise = s_ack_n && ack_low_q;

	// The write is taken at its trailing edge, with the last data seen low.
	always_comb begin
		wr_act_d  = wr_act;
		wr_a0_d   = wr_act ? s_a0 : wr_a0_q;
		wr_data_d = wr_act ? s_data : wr_data_q;
		ack_low_d = !s_ack_n;
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			wr_act_q  <= 1'b0;
			wr_a0_q   <= 1'b0;
			wr_data_q <= 8'h00;
			ack_low_q <= 1'b0;
		end else begin
			wr_act_q  <= wr_act_d;
			wr_a0_q   <= wr_a0_d;
			wr_data_q <= wr_data_d;
			ack_low_q <= ack_low_d;
		end
	end

	// Setup sequence and command words.
	ivs_pkg::ivs_init_t init_q, init_d;
	logic [7:0] base_q, base_d, imr_q, imr_d;
	logic [2:0] addr_lo_q, addr_lo_d, sid_q, sid_d;
	logic       level_trigger_sel_q, level_trigger_sel_d, adi_q, adi_d, lone_device_flag_q, lone_device_flag_d, ic4_q, ic4_d;
	logic       auto_service_clear_q, auto_service_clear_d, pm_q, pm_d, smm_q, smm_d, ris_q, ris_d;
	logic       ready, eoi_stb;

	assign ready   = init_q == ivs_pkg::INIT_READY;
	assign eoi_stb = wr_stb && ready && !wr_a0_q
	                 && !wr_data_q[`IVS_W1_INIT] && !wr_data_q[`IVS_OW_THIRD];

	always_comb begin
		init_d = init_q;  base_d = base_q;  imr_d = imr_q;
		addr_lo_d = addr_lo_q;  sid_d = sid_q;  level_trigger_sel_d = level_trigger_sel_q;
		adi_d = adi_q;  lone_device_flag_d = lone_device_flag_q;  ic4_d = ic4_q;
		auto_service_clear_d = auto_service_clear_q;  pm_d = pm_q;  smm_d = smm_q;  ris_d = ris_q;
		if (wr_init) begin
			init_d    = ivs_pkg::INIT_BASE;
			imr_d     = `IVS_MASK_RST;
			smm_d     = 1'b0;
			ris_d     = 1'b0;
			sid_d     = `IVS_SLAVE_ID_RST;
			addr_lo_d = wr_data_q[`IVS_W1_ADDR_HI:`IVS_W1_ADDR_LO];
			level_trigger_sel_d    = wr_data_q[`IVS_W1_LEVEL_TRIGGER_SEL];
			adi_d     = wr_data_q[`IVS_W1_ADI];
			lone_device_flag_d    = wr_data_q[`IVS_W1_LONE_DEVICE_FLAG];
			ic4_d     = wr_data_q[`IVS_W1_IC4];
			if (!wr_data_q[`IVS_W1_IC4]) begin
				auto_service_clear_d = 1'b0;
				pm_d   = 1'b0;
			end
		end else if (wr_stb && wr_a0_q) begin
			case (init_q)
				ivs_pkg::INIT_BASE: begin
					base_d = wr_data_q;
					if (!lone_device_flag_q)
						init_d = ivs_pkg::INIT_CASC;
					else if (ic4_q)
						init_d = ivs_pkg::INIT_FOURTH;
					else
						init_d = ivs_pkg::INIT_READY;
				end
				ivs_pkg::INIT_CASC: begin
					sid_d  = wr_data_q[2:0];
					init_d = ic4_q ? ivs_pkg::INIT_FOURTH
					               : ivs_pkg::INIT_READY;
				end
				ivs_pkg::INIT_FOURTH: begin
					auto_service_clear_d = wr_data_q[`IVS_W4_AUTO_SERVICE_CLEAR];
					pm_d   = wr_data_q[`IVS_W4_PM];
					init_d = ivs_pkg::INIT_READY;
				end
				ivs_pkg::INIT_READY: imr_d = wr_data_q;
				default: init_d = ivs_pkg::INIT_WAIT;
			endcase
		end else if (wr_stb && ready && wr_data_q[`IVS_OW_THIRD]) begin
			if (wr_data_q[`IVS_OW_ESMM])
				smm_d = wr_data_q[`IVS_OW_SMM];
			if (wr_data_q[`IVS_OW_RR])
				ris_d = wr_data_q[`IVS_OW_RIS];
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			init_q <= ivs_pkg::INIT_WAIT;
			base_q <= 8'h00;  imr_q <= `IVS_MASK_RST;  addr_lo_q <= 3'h0;
			sid_q <= `IVS_SLAVE_ID_RST;  level_trigger_sel_q <= 1'b0;  adi_q <= 1'b0;
			lone_device_flag_q <= 1'b0;  ic4_q <= 1'b0;  auto_service_clear_q <= 1'b0;  pm_q <= 1'b0;
			smm_q <= 1'b0;  ris_q <= 1'b0;
		end else begin
			init_q <= init_d;
			base_q <= base_d;  imr_q <= imr_d;  addr_lo_q <= addr_lo_d;
			sid_q <= sid_d;  level_trigger_sel_q <= level_trigger_sel_d;  adi_q <= adi_d;
			lone_device_flag_q <= lone_device_flag_d;  ic4_q <= ic4_d;  auto_service_clear_q <= auto_service_clear_d;
			pm_q <= pm_d;  smm_q <= smm_d;  ris_q <= ris_d;
		end
	end

	// Requests, service and the acknowledge sequence.
	ivs_pkg::ivs_ack_t   ack_q, ack_d;
	ivs_pkg::ivs_level_t lvl_q, lvl_d, pend_lvl, serv_lvl;
	logic [7:0] irr_q, irr_d, isr_q, isr_d, prev_q, prev_d;
	logic [7:0] req_set, ack_set, done_clr;
	logic       spur_q, spur_d, pend_found, serv_found, ack_end;

	ivs_prio u_pend (
		.bits_i  (irr_q & ~imr_q),
		.found_o (pend_found),
		.level_o (pend_lvl)
	);
	// In special mask mode a masked service bit no longer blocks anything.
	ivs_prio u_serv (
		.bits_i  (smm_q ? (isr_q & ~imr_q) : isr_q),
		.found_o (serv_found),
		.level_o (serv_lvl)
	);

	for (genvar g = 0; g < 8; g++) begin : g_req
		assign req_set[g] = level_trigger_sel_q ? s_req[g]
		                           : s_req[g] && !prev_q[g];
	end

	always_comb begin
		ack_d = ack_q;  lvl_d = lvl_q;  spur_d = spur_q;
		ack_set = 8'h00;  ack_end = 1'b0;  done_clr = 8'h00;
		case (ack_q)
			ivs_pkg::ACK_IDLE: if (ack_fall && ready) begin
				ack_d  = ivs_pkg::ACK_P1;
				lvl_d  = pend_found ? pend_lvl : `IVS_SPUR_LEVEL;
				spur_d = !pend_found;
				if (pend_found)
					ack_set = ivs_onehot(pend_lvl);
			end
			ivs_pkg::ACK_P1: if (ack_rise) ack_d = ivs_pkg::ACK_G1;
			ivs_pkg::ACK_G1: if (ack_fall) ack_d = ivs_pkg::ACK_P2;
			ivs_pkg::ACK_P2: if (ack_rise) begin
				ack_end = pm_q;
				ack_d   = pm_q ? ivs_pkg::ACK_IDLE : ivs_pkg::ACK_G2;
			end
			ivs_pkg::ACK_G2: if (ack_fall) ack_d = ivs_pkg::ACK_P3;
			ivs_pkg::ACK_P3: if (ack_rise) begin
				ack_end = 1'b1;
				ack_d   = ivs_pkg::ACK_IDLE;
			end
			default: ack_d = ivs_pkg::ACK_IDLE;
		endcase
		if (ack_end && auto_service_clear_q && !spur_q)
			done_clr = ivs_onehot(lvl_q);
		if (eoi_stb && wr_data_q[7:5] == `IVS_EOI_NSPEC && serv_found)
			done_clr = done_clr | ivs_onehot(serv_lvl);
		if (eoi_stb && wr_data_q[7:5] == `IVS_EOI_SPEC)
			done_clr = done_clr | ivs_onehot(wr_data_q[2:0]);
		// A new set wins over a clear landing in the same cycle.
		irr_d  = req_set | (irr_q & s_req & ~ack_set);
		isr_d  = (isr_q & ~done_clr) | ack_set;
		prev_d = s_req;
		if (wr_init) begin
			ack_d  = ivs_pkg::ACK_IDLE;
			irr_d  = 8'h00;
			isr_d  = 8'h00;
			prev_d = `IVS_EDGE_REARM;
		end
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			ack_q <= ivs_pkg::ACK_IDLE;  lvl_q <= 3'h0;  spur_q <= 1'b0;
			irr_q <= 8'h00;  isr_q <= 8'h00;  prev_q <= `IVS_EDGE_REARM;
		end else begin
			ack_q <= ack_d;  lvl_q <= lvl_d;  spur_q <= spur_d;
			irr_q <= irr_d;  isr_q <= isr_d;  prev_q <= prev_d;
		end
	end

	// Pin drivers. The acknowledge bytes take precedence over status reads.
	logic [7:0] dout_q, dout_d;
	logic [2:0] cas_q, cas_d;
	logic       doe_n_q, doe_n_d, cas_oe_n_q, cas_oe_n_d, int_q, int_d;

	always_comb begin
		dout_d  = 8'h00;
		doe_n_d = 1'b1;
		case (ack_d)
			ivs_pkg::ACK_P1: if (!pm_q) begin
				dout_d  = `IVS_CALL_OPCODE;
				doe_n_d = 1'b0;
			end
			ivs_pkg::ACK_P2: begin
				doe_n_d = 1'b0;
				if (pm_q)
					dout_d = {base_q[7:3], lvl_q};
				else if (adi_q)
					dout_d = {addr_lo_q, lvl_q, 2'b00};
				else
					dout_d = {addr_lo_q[2:1], lvl_q, 3'b000};
			end
			ivs_pkg::ACK_P3: begin
				dout_d  = base_q;
				doe_n_d = 1'b0;
			end
			ivs_pkg::ACK_IDLE: if (rd_act) begin
				doe_n_d = 1'b0;
				dout_d  = s_a0 ? imr_q : (ris_q ? isr_q : irr_q);
			end
			default: ;
		endcase
		// The code appears after the first pulse ends and stays to the last.
		cas_d      = lvl_q;
		cas_oe_n_d = lone_device_flag_q || ack_d == ivs_pkg::ACK_IDLE
		             || ack_d == ivs_pkg::ACK_P1;
		int_d = ready && pend_found
		        && (!serv_found || pend_lvl < serv_lvl);
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			dout_q <= 8'h00;  doe_n_q <= 1'b1;  cas_q <= 3'h0;
			cas_oe_n_q <= 1'b1;  int_q <= 1'b0;
		end else begin
			dout_q <= dout_d;  doe_n_q <= doe_n_d;  cas_q <= cas_d;
			cas_oe_n_q <= cas_oe_n_d;  int_q <= int_d;
		end
	end

	assign data_o      = dout_q;
	assign data_oe_n_o = doe_n_q;
	assign int_o       = int_q;
	assign cas_o       = cas_q;
	assign cas_oe_n_o  = cas_oe_n_q;
	assign slave_id_o  = sid_q;

	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);

	sequence s_first_ack;
		ack_fall && ready && ack_q == ivs_pkg::ACK_IDLE && !wr_init;
	endsequence

	sequence s_last_end;
		ack_end && auto_service_clear_q && !spur_q && !wr_init;
	endsequence

	AST_CALL_OPCODE: assert property (
		s_first_ack ##0 !pm_q |=> dout_q == 8'hcd && !doe_n_q)
		else $error("call opcode not driven on first ack");
	AST_PTR_QUIET: assert property (
		ack_q == ivs_pkg::ACK_P1 && pm_q |-> doe_n_q)
		else $error("bus driven on first pointer-mode ack");
	AST_SET_SERVICE: assert property (
		s_first_ack ##0 pend_found |=> isr_q[lvl_q] && lvl_q == $past(pend_lvl))
		else $error("service bit not set on first ack");
	AST_SPURIOUS: assert property (
		s_first_ack ##0 !pend_found |=> lvl_q == 3'h7 && isr_q == $past(isr_q))
		else $error("spurious ack not answered as level seven");
	AST_LOW_BYTE_4: assert property (
		ack_q == ivs_pkg::ACK_P2 && !pm_q && adi_q
		|-> dout_q == {addr_lo_q, lvl_q, 2'b00})
		else $error("interval four low byte wrong");
	AST_LOW_BYTE_8: assert property (
		ack_q == ivs_pkg::ACK_P2 && !pm_q && !adi_q
		|-> dout_q[7:6] == addr_lo_q[2:1] && dout_q[5:0] == {lvl_q, 3'b000})
		else $error("interval eight low byte wrong");
	AST_HIGH_BYTE: assert property (
		ack_q == ivs_pkg::ACK_P3 |-> dout_q == base_q && !doe_n_q)
		else $error("third byte is not the base word");
	AST_POINTER: assert property (
		ack_q == ivs_pkg::ACK_P2 && pm_q |-> dout_q == {base_q[7:3], lvl_q})
		else $error("pointer byte wrong");
	AST_AUTO_CLEAR: assert property (
		s_last_end |=> !isr_q[$past(lvl_q)])
		else $error("auto clear left service bit set");
	AST_INIT_START: assert property (
		wr_init |=> imr_q == 8'h00 && !smm_q && !ris_q && sid_q == 3'h7
		            && init_q == ivs_pkg::INIT_BASE)
		else $error("setup start effects missing");
	AST_NO_INT_IDLE: assert property (
		!ready |=> ##1 !int_q || ready)
		else $error("interrupt raised before setup completed");

endmodule : ivs_top

/* File: dv/ivs_host.sv */
`timescale 1ns/1ns
module ivs_host (
	input  wire logic       clock_i,
	input  wire logic [7:0] data_i,
	input  wire logic       data_oe_n_i,
	output logic            cs_n_o,
	output logic            wr_n_o,
	output logic            rd_n_o,
	output logic            a0_o,
	output logic      [7:0] data_o,
	output logic            ack_n_o
);
	initial begin
		cs_n_o = 1'b1;
		wr_n_o = 1'b1;
		rd_n_o = 1'b1;
		a0_o = 1'b0;
		data_o = 8'h00;
		ack_n_o = 1'b1;
	end

	// Strobes are held long enough to pass the two-flop pin synchronisers.
	task automatic wr(input logic a0, input logic [7:0] d);
		@(posedge clock_i);
		#1;
		cs_n_o = 1'b0;
		wr_n_o = 1'b0;
		a0_o = a0;
		data_o = d;
		repeat (4) @(posedge clock_i);
		#1;
		cs_n_o = 1'b1;
		wr_n_o = 1'b1;
		// A released bus must not keep showing the byte just written.
		data_o = ~d;
		a0_o = ~a0;
		repeat (6) @(posedge clock_i);
	endtask : wr

	// Read data is taken while the strobe is still low, after the pin lag.
	task automatic rd(input logic a0, output logic [7:0] d);
		@(posedge clock_i);
		#1;
		cs_n_o = 1'b0;
		rd_n_o = 1'b0;
		a0_o = a0;
		repeat (5) @(posedge clock_i);
		#1;
		d = data_i;
		cs_n_o = 1'b1;
		rd_n_o = 1'b1;
		repeat (5) @(posedge clock_i);
	endtask : rd

	task automatic ack(output logic oe_n, output logic [7:0] d);
		@(posedge clock_i);
		#1;
		ack_n_o = 1'b0;
		repeat (5) @(posedge clock_i);
		#1;
		oe_n = data_oe_n_i;
		d = data_i;
		ack_n_o = 1'b1;
		repeat (5) @(posedge clock_i);
	endtask : ack
endmodule : ivs_host

/* File: dv/ivs_top_tb.sv */
`timescale 1ns/1ns
module ivs_top_tb;
	logic        clock_i;
	logic        reset_i;
	logic [7:0]  request_i;
	logic        cs_n, wr_n, rd_n, a0, ack_n, oe_n, int_o, cas_oe_n;
	logic [7:0]  din, dout, w1, base, d, m;
	logic [2:0]  cas, slave_id, sid;
	logic [31:0] x;
	logic        sp, ic4, pm, ae, oe, lt, sg;
	int          n_fail, checks, it, lvl, hi;

	ivs_top ivs_top_i (.clock_i(clock_i), .reset_i(reset_i), .cs_n_i(cs_n),
		.wr_n_i(wr_n), .rd_n_i(rd_n), .a0_i(a0), .data_i(din),
		.vector_ack_strobe_n_i(ack_n), .request_i(request_i), .data_o(dout),
		.data_oe_n_o(oe_n), .int_o(int_o), .cas_o(cas),
		.cas_oe_n_o(cas_oe_n), .slave_id_o(slave_id));
	ivs_host ivs_host_i (.clock_i(clock_i), .data_i(dout),
		.data_oe_n_i(oe_n), .cs_n_o(cs_n), .wr_n_o(wr_n), .rd_n_o(rd_n),
		.a0_o(a0), .data_o(din), .ack_n_o(ack_n));

	always #5 clock_i = ~clock_i;

	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] t;
		t = v ^ (v << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction : xs

	function automatic logic [7:0] low_byte(input logic [2:0] l);
		return sp ? {w1[7:5], l, 2'b00} : {w1[7:6], l, 3'b000};
	endfunction : low_byte

	task automatic check(input string name, input logic [7:0] seen,
		input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error: %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out

	// Bounded wait for the interrupt line; running out ends the run.
	task automatic wait_int;
		int n;
		n = 0;
		while (int_o !== 1'b1) begin
			@(posedge clock_i);
			#1;
			n++;
			if (n > 40) begin
				n_fail++;
				$display("Error: int_o expected 1 seen %b", int_o);
				close_out();
			end
		end
	endtask : wait_int

	// Between pulses the code stands on the lines unless the device is alone.
	task automatic cas_chk(input logic [2:0] l);
		check("cas_oe_n", {7'h00, cas_oe_n}, {7'h00, sg});
		check("cas", {5'h00, cas}, {5'h00, l});
	endtask : cas_chk

	task automatic vec(input logic [2:0] l);
		if (!pm) begin
			ivs_host_i.ack(oe, d);
			check("opcode", d, 8'hcd);
			cas_chk(l);
			ivs_host_i.ack(oe, d);
			check("low byte", d, low_byte(l));
			ivs_host_i.ack(oe, d);
			check("high byte", d, base);
		end else begin
			ivs_host_i.ack(oe, d);
			check("first oe_n", {7'h00, oe}, 8'h01);
			cas_chk(l);
			ivs_host_i.ack(oe, d);
			check("pointer", d, {base[7:3], l});
		end
		check("oe_n", {7'h00, oe}, 8'h00);
		check("cas released", {7'h00, cas_oe_n}, 8'h01);
	endtask : vec

	initial begin
		clock_i = 1'b0;
		reset_i = 1'b1;
		request_i = 8'h00;
		n_fail = 0;
		checks = 0;
		x = 32'h052dbf5e;
		repeat (5) @(posedge clock_i);
		#1;
		reset_i = 1'b0;
		check("reset int", {7'h00, int_o}, 8'h00);
		ivs_host_i.ack(oe, d);
		check("unready ack", {7'h00, oe}, 8'h01);
		$display("test reset done");
		for (it = 0; it < 16; it++) begin
			x = xs(x);
			sp = x[0];
			ic4 = x[1];
			// Without a fourth word, call mode and no auto clear are expected.
			pm = ic4 & x[2];
			ae = ic4 & x[3];
			lvl = (x[6:4] == 3'h7) ? 6 : int'(x[6:4]);
			hi = lvl + 1 + int'(x[10:8]) % (7 - lvl);
			lt = x[12];
			sg = x[11];
			sid = x[27:25];
			w1 = {x[15:13], 1'b1, lt, sp, sg, ic4};
			base = x[23:16];
			@(posedge clock_i);
			#1;
			request_i = 8'h00;
			repeat (4) @(posedge clock_i);
			ivs_host_i.wr(1'b0, w1);
			check("slave id", {5'h00, slave_id}, 8'h07);
			ivs_host_i.wr(1'b1, base);
			if (!sg) begin
				ivs_host_i.wr(1'b1, {5'h00, sid});
				check("cascade id", {5'h00, slave_id}, {5'h00, sid});
			end
			if (ic4) begin
				ivs_host_i.wr(1'b1, {6'h00, ae, pm});
			end
			@(posedge clock_i);
			#1;
			if (it % 4 == 3) begin
				request_i = 8'h04;
				wait_int();
				request_i = 8'h00;
				repeat (8) @(posedge clock_i);
				vec(3'h7);
			end else begin
				request_i = (8'h01 << lvl) | (8'h01 << hi);
				wait_int();
				// Only idle inputs are masked, so service is unaffected.
				m = x[31:24] & ~request_i;
				ivs_host_i.wr(1'b1, m);
				ivs_host_i.rd(1'b0, d);
				check("requests", d, request_i);
				ivs_host_i.rd(1'b1, d);
				check("mask", d, m);
				vec(lvl[2:0]);
				repeat (8) @(posedge clock_i);
				#1;
				// The lower request stays blocked until the level is cleared.
				check("int after", {7'h00, int_o}, {7'h00, ae});
				if (!ae) begin
					ivs_host_i.wr(1'b0, 8'h0b);
					ivs_host_i.rd(1'b0, d);
					check("service", d, 8'h01 << lvl);
					m = x[7] ? 8'h20 : {5'h0c, lvl[2:0]};
					ivs_host_i.wr(1'b0, m);
					wait_int();
				end
			end
			$display("test %0d done", it);
		end
		close_out();
	end
endmodule : ivs_top_tb
